// ===== sles_lane_status.sv
// Serial lane error status: deskew status, per-lane error flags and APB registers.
// Assumes lane inputs are synchronous to mclk and error hits are one-cycle pulses.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module sles_lane_status (
  // Clock and reset
  input  wire logic                                   mclk,
  input  wire logic                                   srst,
  // APB slave
  input  wire logic [sles_pkg::SLES_ADDR_W-1:0]       paddr,
  input  wire logic                                   psel,
  input  wire logic                                   penable,
  input  wire logic                                   pwrite,
  input  wire logic [31:0]                            pwdata,
  input  wire logic [3:0]                             pstrb,
  output logic      [31:0]                            prdata,
  output logic                                        pready,
  output logic                                        pslverr,
  // Lane receiver status
  input  wire logic [sles_pkg::SLES_DESKEW_LANES-1:0] lane_deskew_done,
  input  wire logic [sles_pkg::SLES_LANES-1:0]        lane_disparity_hit,
  input  wire logic [sles_pkg::SLES_LANES-1:0]        lane_invalid_code_hit,
  // Control and interrupt
  output logic                                        skip_alignment_sequence,
  output logic                                        irq
);

  typedef struct packed {
    sles_pkg::sles_apb_e               apb_st;
    logic                              pready;
    logic                              pslverr;
    logic [31:0]                       prdata;
    logic [7:0]                        thresh;
    logic                              skip;
    sles_pkg::sles_align_s             align;
    logic [sles_pkg::SLES_LANES-1:0]   disp_prev;
    logic [sles_pkg::SLES_LANES-1:0]   invc_prev;
  } sles_top_s;

  sles_top_s state_ff;
  sles_top_s nxt_state;

  // Counter banks
  sles_cnt_if disp_bank ();
  sles_cnt_if invc_bank ();

  logic [sles_pkg::SLES_IRQ_W-1:0] irq_event;
  logic [sles_pkg::SLES_IRQ_W-1:0] irq_status;
  logic [sles_pkg::SLES_IRQ_W-1:0] irq_mask;
  logic                            irq_clr_we;
  logic                            irq_mask_we;
  logic                            wr_commit;
  logic                            access_first;
  logic                            addr_mapped;
  logic [31:0]                     rd_mux;
  logic [3:0]                      align_now;
  logic [3:0]                      align_old;

  assign disp_bank.err_hit = lane_disparity_hit;
  assign disp_bank.thresh  = state_ff.thresh;
  assign invc_bank.err_hit = lane_invalid_code_hit;
  assign invc_bank.thresh  = state_ff.thresh;

  sles_err_cnt u_disp_cnt (
    .mclk (mclk),
    .srst (srst),
    .bank (disp_bank.cnt)
  );

  sles_err_cnt u_invc_cnt (
    .mclk (mclk),
    .srst (srst),
    .bank (invc_bank.cnt)
  );

  // A read-only word is accepted on write and ignored; only holes in the map error out
  always_comb begin
    addr_mapped = 1'b1;
    rd_mux      = 32'h0000_0000;
    case (paddr)
      sles_pkg::SLES_ADDR_ALIGN: begin
        rd_mux[7:0] = state_ff.align;
      end
      sles_pkg::SLES_ADDR_DISP: begin
        rd_mux[7:0] = disp_bank.flags;
      end
      sles_pkg::SLES_ADDR_INVC: begin
        rd_mux[7:0] = invc_bank.flags;
      end
      sles_pkg::SLES_ADDR_THRESH: begin
        rd_mux[7:0] = state_ff.thresh;
      end
      sles_pkg::SLES_ADDR_CTRL: begin
        rd_mux[sles_pkg::SLES_CTRL_SKIP] = state_ff.skip;
      end
      sles_pkg::SLES_ADDR_IRQ_STAT: begin
        rd_mux[sles_pkg::SLES_IRQ_W-1:0] = irq_status;
      end
      sles_pkg::SLES_ADDR_IRQ_MASK: begin
        rd_mux[sles_pkg::SLES_IRQ_W-1:0] = irq_mask;
      end
      default: begin
        addr_mapped = 1'b0;
      end
    endcase
  end

  assign access_first = psel && penable && (state_ff.apb_st == sles_pkg::SLES_APB_IDLE);
  // Writes land on the edge where the master samples pready high
  assign wr_commit    = psel && penable && pwrite && pstrb[0] && addr_mapped
                        && (state_ff.apb_st == sles_pkg::SLES_APB_ANSWER);
  assign irq_clr_we   = wr_commit && (paddr == sles_pkg::SLES_ADDR_IRQ_STAT);
  assign irq_mask_we  = wr_commit && (paddr == sles_pkg::SLES_ADDR_IRQ_MASK);

  assign align_now = lane_deskew_done;
  assign align_old = {state_ff.align.lane3_aligned, state_ff.align.lane2_aligned,
                      state_ff.align.lane1_aligned, state_ff.align.lane0_aligned};

  // Events: a flag newly raised, or an aligned lane dropping out
  always_comb begin
    irq_event = '0;
    irq_event[sles_pkg::SLES_IRQ_DISP] = |(disp_bank.flags & ~state_ff.disp_prev);
    irq_event[sles_pkg::SLES_IRQ_INVC] = |(invc_bank.flags & ~state_ff.invc_prev);
    // Deskew status means nothing without the alignment sequence, so no event then
    irq_event[sles_pkg::SLES_IRQ_ALIGN] = !state_ff.skip && |(align_old & ~align_now);
  end

  sles_irq_ctrl u_irq (
    .mclk      (mclk),
    .srst      (srst),
    .event_hit (irq_event),
    .clr_we    (irq_clr_we),
    .mask_we   (irq_mask_we),
    .wdata     (pwdata[sles_pkg::SLES_IRQ_W-1:0]),
    .status    (irq_status),
    .mask      (irq_mask),
    .irq       (irq)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_state.align.unused_hi     = 4'h0;
    nxt_state.align.lane3_aligned = align_now[3];
    nxt_state.align.lane2_aligned = align_now[2];
    nxt_state.align.lane1_aligned = align_now[1];
    nxt_state.align.lane0_aligned = align_now[0];
    nxt_state.disp_prev = disp_bank.flags;
    nxt_state.invc_prev = invc_bank.flags;
    case (state_ff.apb_st)
      sles_pkg::SLES_APB_IDLE: begin
        // One wait state buys a registered read path
        if (access_first) begin
          nxt_state.apb_st  = sles_pkg::SLES_APB_ANSWER;
          nxt_state.pready  = 1'b1;
          nxt_state.pslverr = !addr_mapped;
          nxt_state.prdata  = pwrite ? 32'h0000_0000 : rd_mux;
        end
      end
      sles_pkg::SLES_APB_ANSWER: begin
        nxt_state.apb_st  = sles_pkg::SLES_APB_IDLE;
        nxt_state.pready  = 1'b0;
        nxt_state.pslverr = 1'b0;
        if (wr_commit && (paddr == sles_pkg::SLES_ADDR_THRESH)) begin
          nxt_state.thresh = pwdata[7:0];
        end
        if (wr_commit && (paddr == sles_pkg::SLES_ADDR_CTRL)) begin
          nxt_state.skip = pwdata[sles_pkg::SLES_CTRL_SKIP];
        end
      end
      default: begin
        nxt_state.apb_st = sles_pkg::SLES_APB_IDLE;
        nxt_state.pready = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_ff        <= '0;
      state_ff.thresh <= sles_pkg::SLES_THRESH_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign prdata                  = state_ff.prdata;
  assign pready                  = state_ff.pready;
  assign pslverr                 = state_ff.pslverr;
  assign skip_alignment_sequence = state_ff.skip;

  // Bus phases used by the checks below
  sequence s_read_first(logic [sles_pkg::SLES_ADDR_W-1:0] a);
    psel && penable && !pwrite && (paddr == a) && (state_ff.apb_st == sles_pkg::SLES_APB_IDLE);
  endsequence

  sequence s_answer;
    pready && (state_ff.apb_st == sles_pkg::SLES_APB_ANSWER);
  endsequence

  AST_ALIGN_RESET: assert property (@(posedge mclk)
    srst |=> (state_ff.align == 8'h00))
    else $error("deskew status not cleared by reset");

  AST_ALIGN_TRACK: assert property (@(posedge mclk) disable iff (srst)
    ##1 (align_old == $past(lane_deskew_done)) && (state_ff.align.unused_hi == 4'h0))
    else $error("deskew status does not follow the deskew result");

  AST_DISP_READ: assert property (@(posedge mclk) disable iff (srst)
    s_read_first(sles_pkg::SLES_ADDR_DISP)
      |=> s_answer ##0 (prdata == {24'h00_0000, $past(disp_bank.flags)}) && !pslverr)
    else $error("bad-disparity byte read returned wrong data");

  AST_INVC_READ: assert property (@(posedge mclk) disable iff (srst)
    s_read_first(sles_pkg::SLES_ADDR_INVC)
      |=> s_answer ##0 (prdata == {24'h00_0000, $past(invc_bank.flags)}) && !pslverr)
    else $error("invalid-code byte read returned wrong data");

  AST_FLAGS_RESET: assert property (@(posedge mclk)
    srst ##1 srst |=> (disp_bank.flags == 8'h00) && (invc_bank.flags == 8'h00))
    else $error("error flags not cleared by reset");

  AST_THRESH_WRITE: assert property (@(posedge mclk) disable iff (srst)
    (wr_commit && (paddr == sles_pkg::SLES_ADDR_THRESH)) |=> (state_ff.thresh == $past(pwdata[7:0])))
    else $error("threshold write did not take effect");

  AST_READY_PULSE: assert property (@(posedge mclk) disable iff (srst)
    access_first |=> pready ##1 !pready)
    else $error("pready is not a single-cycle answer");

  AST_UNMAPPED_ERR: assert property (@(posedge mclk) disable iff (srst)
    (access_first && !addr_mapped) |=> pslverr && pready)
    else $error("unmapped access not answered with an error");

  AST_SKIP_NO_EVENT: assert property (@(posedge mclk) disable iff (srst)
    (state_ff.skip && !irq_status[sles_pkg::SLES_IRQ_ALIGN]) |=> !irq_status[sles_pkg::SLES_IRQ_ALIGN])
    else $error("alignment event raised while alignment sequence skipped");

endmodule : sles_lane_status
`default_nettype wire

// ===== sles_pkg.sv
// Constants, register map and state types for the serial lane error status block.
// Assumes a 32-bit APB slave with word registers at four times their index.
package sles_pkg;

  // Lane counts and widths
  localparam int unsigned SLES_LANES        = 8;
  localparam int unsigned SLES_DESKEW_LANES = 4;
  localparam int unsigned SLES_CNT_W        = 8;
  localparam int unsigned SLES_IDX_W        = 14;
  localparam int unsigned SLES_ADDR_W       = 16;
  localparam int unsigned SLES_IRQ_W        = 3;

  // Register indices; byte address is four times the index
  localparam logic [SLES_IDX_W-1:0] SLES_IDX_ALIGN    = 14'h046c;
  localparam logic [SLES_IDX_W-1:0] SLES_IDX_DISP     = 14'h046d;
  localparam logic [SLES_IDX_W-1:0] SLES_IDX_INVC     = 14'h046e;
  localparam logic [SLES_IDX_W-1:0] SLES_IDX_THRESH   = 14'h0480;
  localparam logic [SLES_IDX_W-1:0] SLES_IDX_CTRL     = 14'h0481;
  localparam logic [SLES_IDX_W-1:0] SLES_IDX_IRQ_STAT = 14'h0482;
  localparam logic [SLES_IDX_W-1:0] SLES_IDX_IRQ_MASK = 14'h0483;

  localparam logic [SLES_ADDR_W-1:0] SLES_ADDR_ALIGN    = {SLES_IDX_ALIGN, 2'h0};
  localparam logic [SLES_ADDR_W-1:0] SLES_ADDR_DISP     = {SLES_IDX_DISP, 2'h0};
  localparam logic [SLES_ADDR_W-1:0] SLES_ADDR_INVC     = {SLES_IDX_INVC, 2'h0};
  localparam logic [SLES_ADDR_W-1:0] SLES_ADDR_THRESH   = {SLES_IDX_THRESH, 2'h0};
  localparam logic [SLES_ADDR_W-1:0] SLES_ADDR_CTRL     = {SLES_IDX_CTRL, 2'h0};
  localparam logic [SLES_ADDR_W-1:0] SLES_ADDR_IRQ_STAT = {SLES_IDX_IRQ_STAT, 2'h0};
  localparam logic [SLES_ADDR_W-1:0] SLES_ADDR_IRQ_MASK = {SLES_IDX_IRQ_MASK, 2'h0};

  // Reset values and field positions
  localparam logic [7:0]            SLES_THRESH_RST = 8'h08;
  localparam logic [SLES_CNT_W-1:0] SLES_CNT_MAX    = 8'hff;
  localparam int unsigned           SLES_CTRL_SKIP  = 0;
  localparam int unsigned           SLES_IRQ_DISP   = 0;
  localparam int unsigned           SLES_IRQ_INVC   = 1;
  localparam int unsigned           SLES_IRQ_ALIGN  = 2;

  // Alignment status byte, lanes 7 to 4 read as zero
  typedef struct packed {
    logic [3:0] unused_hi;
    logic       lane3_aligned;
    logic       lane2_aligned;
    logic       lane1_aligned;
    logic       lane0_aligned;
  } sles_align_s;

  typedef enum logic {
    SLES_APB_IDLE,
    SLES_APB_ANSWER
  } sles_apb_e;

endpackage : sles_pkg

// ===== sles_cnt_if.sv
// Carrier between the status top and one bank of per-lane error counters.
// Assumes all signals live in the mclk domain.
`timescale 1ns/1ps
`default_nettype none
interface sles_cnt_if;
  logic [sles_pkg::SLES_LANES-1:0] err_hit;
  logic [7:0]                      thresh;
  logic [sles_pkg::SLES_LANES-1:0] flags;

  modport src (output err_hit, output thresh, input flags);
  modport cnt (input err_hit, input thresh, output flags);
endinterface : sles_cnt_if
`default_nettype wire

// ===== sles_err_cnt.sv
// Per-lane saturating error counters with threshold compare for one error type.
// Assumes one-cycle error pulses per lane, synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module sles_err_cnt (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // Counter bank
  sles_cnt_if.cnt   bank
);

  typedef struct packed {
    logic [sles_pkg::SLES_LANES-1:0][sles_pkg::SLES_CNT_W-1:0] cnt;
    logic [sles_pkg::SLES_LANES-1:0]                           flag;
  } sles_cnt_s;

  sles_cnt_s state_ff;
  sles_cnt_s nxt_state;

  always_comb begin
    nxt_state = state_ff;
    for (int i = 0; i < int'(sles_pkg::SLES_LANES); i++) begin
      // Saturate so a noisy lane cannot wrap back under the threshold
      if (bank.err_hit[i] && (state_ff.cnt[i] != sles_pkg::SLES_CNT_MAX)) begin
        nxt_state.cnt[i] = state_ff.cnt[i] + 8'h01;
      end
      nxt_state.flag[i] = (state_ff.cnt[i] >= bank.thresh);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign bank.flags = state_ff.flag;

  AST_CNT_SATURATES: assert property (@(posedge mclk) disable iff (srst)
    (state_ff.cnt[0] == sles_pkg::SLES_CNT_MAX) |=> (state_ff.cnt[0] == sles_pkg::SLES_CNT_MAX))
    else $error("lane 0 error counter left saturation");

  AST_CNT_STEPS: assert property (@(posedge mclk) disable iff (srst)
    (bank.err_hit[0] && (state_ff.cnt[0] != sles_pkg::SLES_CNT_MAX))
      |=> (state_ff.cnt[0] == $past(state_ff.cnt[0]) + 8'h01))
    else $error("lane 0 error counter missed an error");

  AST_FLAG_COMPARE: assert property (@(posedge mclk) disable iff (srst)
    ##1 (state_ff.flag[0] == ($past(state_ff.cnt[0]) >= $past(bank.thresh))))
    else $error("lane 0 flag disagrees with count versus threshold");

endmodule : sles_err_cnt
`default_nettype wire

// ===== sles_irq_ctrl.sv
// Sticky event status with write-one-to-clear, mask, and one level interrupt.
// Assumes event pulses and write strobes are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module sles_irq_ctrl (
  // Clock and reset
  input  wire logic                              mclk,
  input  wire logic                              srst,
  // Events and register writes
  input  wire logic [sles_pkg::SLES_IRQ_W-1:0]   event_hit,
  input  wire logic                              clr_we,
  input  wire logic                              mask_we,
  input  wire logic [sles_pkg::SLES_IRQ_W-1:0]   wdata,
  // State
  output logic      [sles_pkg::SLES_IRQ_W-1:0]   status,
  output logic      [sles_pkg::SLES_IRQ_W-1:0]   mask,
  output logic                                   irq
);

  typedef struct packed {
    logic [sles_pkg::SLES_IRQ_W-1:0] status;
    logic [sles_pkg::SLES_IRQ_W-1:0] mask;
    logic                            irq;
  } sles_irq_s;

  sles_irq_s state_ff;
  sles_irq_s nxt_state;

  always_comb begin
    nxt_state = state_ff;
    // Set after clear, so an event in the clearing cycle survives
    if (clr_we) begin
      nxt_state.status = state_ff.status & ~wdata;
    end
    nxt_state.status = nxt_state.status | event_hit;
    if (mask_we) begin
      nxt_state.mask = wdata;
    end
    nxt_state.irq = |(state_ff.status & state_ff.mask);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign status = state_ff.status;
  assign mask   = state_ff.mask;
  assign irq    = state_ff.irq;

  AST_IRQ_SET_WINS: assert property (@(posedge mclk) disable iff (srst)
    (event_hit[0] && clr_we && wdata[0]) |=> status[0])
    else $error("event lost against a clear");

  AST_IRQ_LEVEL: assert property (@(posedge mclk) disable iff (srst)
    ##1 (irq == $past(|(state_ff.status & state_ff.mask))))
    else $error("interrupt level does not follow masked status");

endmodule : sles_irq_ctrl
`default_nettype wire

// ===== sles_lane_src.sv
// Far-side lane model: error pulses per lane and deskew levels, driven by bench commands.
// Assumes commands are synchronous to mclk and one burst runs at a time.
`timescale 1ns/1ps
`default_nettype none
module sles_lane_src (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // Bench commands
  input  wire logic       start,
  input  wire logic [7:0] disp_mask,
  input  wire logic [7:0] invc_mask,
  input  wire logic [9:0] count,
  input  wire logic [3:0] gap,
  input  wire logic [3:0] align,
  output logic            busy,
  // Lane outputs
  output logic [3:0]      lane_deskew_done,
  output logic [7:0]      lane_disparity_hit,
  output logic [7:0]      lane_invalid_code_hit
);
  logic [9:0] rem_ff;
  logic [3:0] wait_ff;
  logic [7:0] disp_ff;
  logic [7:0] invc_ff;

  assign busy = (rem_ff != 10'h000);

  // A gap of zero sends a pulse every cycle; larger gaps model a slow source
  always_ff @(posedge mclk) begin
    if (srst) begin
      rem_ff                <= 10'h000;
      wait_ff               <= 4'h0;
      disp_ff               <= 8'h00;
      invc_ff               <= 8'h00;
      lane_deskew_done      <= 4'h0;
      lane_disparity_hit    <= 8'h00;
      lane_invalid_code_hit <= 8'h00;
    end else begin
      lane_deskew_done      <= align;
      lane_disparity_hit    <= 8'h00;
      lane_invalid_code_hit <= 8'h00;
      if (start) begin
        rem_ff  <= count;
        wait_ff <= 4'h0;
        disp_ff <= disp_mask;
        invc_ff <= invc_mask;
      end else if (rem_ff != 10'h000 && wait_ff != 4'h0) begin
        wait_ff <= wait_ff - 4'h1;
      end else if (rem_ff != 10'h000) begin
        lane_disparity_hit    <= disp_ff;
        lane_invalid_code_hit <= invc_ff;
        rem_ff                <= rem_ff - 10'h001;
        wait_ff               <= gap;
      end
    end
  end
endmodule : sles_lane_src
`default_nettype wire

// ===== sles_lane_status_tb.sv
// Self-checking bench for the lane error status block over APB with the lane model.
// Assumes the package, interface and design modules are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sles_lane_status_tb;
  logic                              mclk;
  logic                              srst;
  logic [sles_pkg::SLES_ADDR_W-1:0]  paddr;
  logic                              psel;
  logic                              penable;
  logic                              pwrite;
  logic [31:0]                       pwdata;
  logic [3:0]                        pstrb;
  logic [31:0]                       prdata;
  logic                              pready;
  logic                              pslverr;
  logic [3:0]                        deskew;
  logic [7:0]                        disp_hit;
  logic [7:0]                        invc_hit;
  logic                              skip;
  logic                              irq;
  logic                              src_start;
  logic [7:0]                        src_disp;
  logic [7:0]                        src_invc;
  logic [9:0]                        src_count;
  logic [3:0]                        src_gap;
  logic [3:0]                        src_align;
  logic                              src_busy;
  logic [31:0]                       rd_data;
  logic                              rd_err;
  int                                fails;
  int                                n_tests;
  int                                cycles;
  logic [15:0] rst_addr [7] = '{sles_pkg::SLES_ADDR_ALIGN, sles_pkg::SLES_ADDR_DISP, sles_pkg::SLES_ADDR_INVC,
                                 sles_pkg::SLES_ADDR_THRESH, sles_pkg::SLES_ADDR_CTRL,
                                 sles_pkg::SLES_ADDR_IRQ_STAT, sles_pkg::SLES_ADDR_IRQ_MASK};
  logic [31:0] rst_val [7]  = '{32'h0, 32'h0, 32'h0, 32'h8, 32'h0, 32'h0, 32'h0};

  sles_lane_status sles_lane_status_inst (
    .mclk(mclk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lane_deskew_done(deskew), .lane_disparity_hit(disp_hit), .lane_invalid_code_hit(invc_hit),
    .skip_alignment_sequence(skip), .irq(irq));

  sles_lane_src sles_lane_src_inst (
    .mclk(mclk), .srst(srst), .start(src_start), .disp_mask(src_disp), .invc_mask(src_invc),
    .count(src_count), .gap(src_gap), .align(src_align), .busy(src_busy),
    .lane_deskew_done(deskew), .lane_disparity_hit(disp_hit), .lane_invalid_code_hit(invc_hit));

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // Request is held until pready is sampled high; no fixed latency assumed
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      final_report();
    end
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd_data, exp);
  endtask : rd_chk

  task automatic burst(input logic [7:0] dm, input logic [7:0] im, input logic [9:0] cnt, input logic [3:0] gp);
    int n;
    n = 0;
    @(posedge mclk);
    src_disp  <= dm;
    src_invc  <= im;
    src_count <= cnt;
    src_gap   <= gp;
    src_start <= 1'b1;
    @(posedge mclk);
    src_start <= 1'b0;
    do begin
      @(posedge mclk);
      n++;
    end while (src_busy === 1'b1 && n < 2000);
    if (src_busy === 1'b1) begin
      fails++;
      final_report();
    end
    // Let count and flag pipeline settle
    repeat (3) @(posedge mclk);
  endtask : burst

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Whole run needs under 3000 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    fails = 0; n_tests = 0; cycles = 0;
    srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 16'h0; pwdata = 32'h0; pstrb = 4'hf;
    src_start = 1'b0; src_disp = 8'h0; src_invc = 8'h0; src_count = 10'h0; src_gap = 4'h0; src_align = 4'h0;
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 0; i < 7; i++) rd_chk(rst_addr[i], rst_val[i]);
    check({31'h0, skip}, 32'h0);
    xfer(1'b0, 16'h1100, 32'h0);
    check(rd_data, 32'h0);
    check({31'h0, rd_err}, 32'h1);
    xfer(1'b1, sles_pkg::SLES_ADDR_DISP, 32'hff);
    rd_chk(sles_pkg::SLES_ADDR_DISP, 32'h0);
    xfer(1'b1, sles_pkg::SLES_ADDR_INVC, 32'hff);
    rd_chk(sles_pkg::SLES_ADDR_INVC, 32'h0);
    xfer(1'b1, sles_pkg::SLES_ADDR_ALIGN, 32'hff);
    rd_chk(sles_pkg::SLES_ADDR_ALIGN, 32'h0);
    src_align <= 4'ha;
    repeat (2) @(posedge mclk);
    rd_chk(sles_pkg::SLES_ADDR_ALIGN, 32'h0a);
    src_align <= 4'hf;
    repeat (2) @(posedge mclk);
    rd_chk(sles_pkg::SLES_ADDR_ALIGN, 32'h0f);
    // Threshold boundary: one below, then equal
    xfer(1'b1, sles_pkg::SLES_ADDR_THRESH, 32'h3);
    burst(8'h81, 8'h00, 10'd2, 4'h0);
    rd_chk(sles_pkg::SLES_ADDR_DISP, 32'h0);
    burst(8'h81, 8'h00, 10'd1, 4'h2);
    rd_chk(sles_pkg::SLES_ADDR_DISP, 32'h81);
    rd_chk(sles_pkg::SLES_ADDR_INVC, 32'h0);
    burst(8'h00, 8'h20, 10'd3, 4'h1);
    rd_chk(sles_pkg::SLES_ADDR_INVC, 32'h20);
    // 300 hits would wrap to 44 without saturation
    xfer(1'b1, sles_pkg::SLES_ADDR_THRESH, 32'hff);
    burst(8'h03, 8'h00, 10'd300, 4'h0);
    rd_chk(sles_pkg::SLES_ADDR_DISP, 32'h03);
    rd_chk(sles_pkg::SLES_ADDR_INVC, 32'h0);
    xfer(1'b1, sles_pkg::SLES_ADDR_THRESH, 32'h0);
    rd_chk(sles_pkg::SLES_ADDR_DISP, 32'hff);
    rd_chk(sles_pkg::SLES_ADDR_INVC, 32'hff);
    // A write without the byte-lane 0 strobe is answered and dropped
    pstrb <= 4'he;
    xfer(1'b1, sles_pkg::SLES_ADDR_THRESH, 32'h55);
    pstrb <= 4'hf;
    rd_chk(sles_pkg::SLES_ADDR_THRESH, 32'h0);
    // Interrupt: sticky status, mask, write-one-to-clear
    rd_chk(sles_pkg::SLES_ADDR_IRQ_STAT, 32'h3);
    check({31'h0, irq}, 32'h0);
    xfer(1'b1, sles_pkg::SLES_ADDR_IRQ_MASK, 32'h7);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h1);
    xfer(1'b1, sles_pkg::SLES_ADDR_IRQ_STAT, 32'h3);
    rd_chk(sles_pkg::SLES_ADDR_IRQ_STAT, 32'h0);
    check({31'h0, irq}, 32'h0);
    src_align <= 4'h8;
    repeat (3) @(posedge mclk);
    rd_chk(sles_pkg::SLES_ADDR_IRQ_STAT, 32'h4);
    check({31'h0, irq}, 32'h1);
    rd_chk(sles_pkg::SLES_ADDR_ALIGN, 32'h08);
    xfer(1'b1, sles_pkg::SLES_ADDR_IRQ_MASK, 32'h3);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0);
    xfer(1'b1, sles_pkg::SLES_ADDR_IRQ_STAT, 32'h4);
    // Deskew bits are not trusted while the alignment sequence is skipped
    xfer(1'b1, sles_pkg::SLES_ADDR_CTRL, 32'h1);
    repeat (2) @(posedge mclk);
    check({31'h0, skip}, 32'h1);
    src_align <= 4'h0;
    repeat (3) @(posedge mclk);
    rd_chk(sles_pkg::SLES_ADDR_IRQ_STAT, 32'h0);
    rd_chk(sles_pkg::SLES_ADDR_CTRL, 32'h1);
    // Mid-run reset must clear the saturated counters, not only the flags
    srst <= 1'b1;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    rd_chk(sles_pkg::SLES_ADDR_DISP, 32'h0);
    rd_chk(sles_pkg::SLES_ADDR_INVC, 32'h0);
    rd_chk(sles_pkg::SLES_ADDR_THRESH, {24'h00_0000, sles_pkg::SLES_THRESH_RST});
    check({31'h0, skip}, 32'h0);
    // Flag rises at the very edge where its status bit is cleared: the event must win
    xfer(1'b1, sles_pkg::SLES_ADDR_THRESH, 32'h1);
    src_disp  <= 8'h01;
    src_count <= 10'd1;
    src_start <= 1'b1;
    @(posedge mclk);
    src_start <= 1'b0;
    xfer(1'b1, sles_pkg::SLES_ADDR_IRQ_STAT, 32'h1);
    rd_chk(sles_pkg::SLES_ADDR_IRQ_STAT, 32'h1);
    rd_chk(sles_pkg::SLES_ADDR_DISP, 32'h01);
    final_report();
  end
endmodule : sles_lane_status_tb
`default_nettype wire
